// ===== logic/marker_block_compare_defines.vh
`ifndef MARKER_BLOCK_COMPARE_DEFINES_VH
`define MARKER_BLOCK_COMPARE_DEFINES_VH

// marker memory geometry
`define MEM_BYTES        1024
`define MEM_ADDR_W       10
`define MAX_COUNT        192
`define COUNT_W          8

// register offsets (word index on the register port)
`define REG_CTRL         4'h0
`define REG_STATUS       4'h1
`define REG_MASK         4'h2
`define REG_RESULT       4'h3

// control register fields
`define CTRL_HONOR_EN    0
`define CTRL_RESET       8'h01

// status and mask fields
`define EVT_DONE         0
`define EVT_MISMATCH     1
`define EVT_ERROR        2
`define EVT_W            3
`define MASK_RESET       3'h0

// result register fields
`define RES_EQUAL        0
`define RES_OVERRUN      1
`define RES_OVERLAP      2
`define RES_BOUNDS       3
`define RES_BUSY         4

`endif

// ===== logic/range_limit_check.v
`timescale 1ns/1ps
`include "marker_block_compare_defines.vh"

module range_limit_check #(
  parameter OFFSET_W  = 32,
  parameter MEM_BYTES = `MEM_BYTES,
  parameter MAX_COUNT = `MAX_COUNT
) (
  input  wire [OFFSET_W-1:0] srcOffset,
  input  wire [OFFSET_W-1:0] dstOffset,
  input  wire [OFFSET_W-1:0] count,
  output wire                overrun,
  output wire                overlap,
  output wire                outOfBounds
);
  localparam [OFFSET_W:0] MEM_LIM = MEM_BYTES;
  localparam [OFFSET_W:0] CNT_LIM = MAX_COUNT;

  wire [OFFSET_W:0] srcExt = {1'b0, srcOffset};
  wire [OFFSET_W:0] dstExt = {1'b0, dstOffset};
  wire [OFFSET_W:0] cntExt = {1'b0, count};
  wire [OFFSET_W:0] srcEnd = srcExt + cntExt;
  wire [OFFSET_W:0] dstEnd = dstExt + cntExt;

  wire cntZero = (count == {OFFSET_W{1'b0}});

  assign outOfBounds = cntZero || (srcExt >= MEM_LIM) || (dstExt >= MEM_LIM);

  assign overrun = !outOfBounds &&
                   ((cntExt > CNT_LIM) || (srcEnd > MEM_LIM) || (dstEnd > MEM_LIM));

  assign overlap = !cntZero && (srcExt < dstEnd) && (dstExt < srcEnd);
endmodule // range_limit_check

// ===== logic/event_status.v
`timescale 1ns/1ps

module event_status #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] setEvents,
  input  wire         clearWrite,
  input  wire [W-1:0] clearBits,
  output wire [W-1:0] statusBits
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      reg sticky_reg;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sticky_reg <= 1'b0;
        end else if (ce) begin
          // a new event beats a same-cycle clear
          if (setEvents[i]) begin
            sticky_reg <= 1'b1;
          end else if (clearWrite && clearBits[i]) begin
            sticky_reg <= 1'b0;
          end
        end
      end
      assign statusBits[i] = sticky_reg;
    end
  endgenerate
endmodule // event_status

// ===== logic/marker_block_compare.v
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "marker_block_compare_defines.vh"

// Overview of operation
// - compare the two ranges byte by byte, whatever the marker type.
// - either range may sit anywhere in the 1024-byte marker memory.
// - the word-only upper region is also reached byte by byte.
// - source and destination start offsets are sampled when a comparison starts.
// - an offset counts from the first marker byte; zero is that byte.
// - count gives bytes per range, up to 192.
// - equal flag high when all byte pairs match, low otherwise.
// - first error when count runs past the source or destination range.
// - second error when the two ranges share any byte.
// - third error when a range starts outside memory or the count is zero.
// - range checks run every cycle, independent of the enable input.
// - comparison runs only while enable is high, if enable is honoured.
// - a control bit chooses whether the enable input is honoured.
// - no retentive state; everything returns to reset values.
module marker_block_compare #(
  parameter OFFSET_W  = 32,
  parameter MEM_BYTES = `MEM_BYTES,
  parameter MAX_COUNT = `MAX_COUNT
) (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   ce,
  input  wire                   evalStart,
  input  wire                   enableIn,
  input  wire [OFFSET_W-1:0]    sourceStartOffset,
  input  wire [OFFSET_W-1:0]    destStartOffset,
  input  wire [OFFSET_W-1:0]    byteCount,
  input  wire [3:0]             regAddr,
  input  wire [7:0]             regWrData,
  input  wire                   regWr,
  input  wire                   regRd,
  output reg  [7:0]             regRdData,
  output reg  [`MEM_ADDR_W-1:0] memAddr,
  output reg                    memRd,
  input  wire [7:0]             memRdData,
  output reg                    rangesEqualFlag,
  output reg                    countOverrunError,
  output reg                    rangeOverlapError,
  output reg                    outOfBoundsError,
  output reg                    busy,
  output reg                    irq
);
  localparam AW = `MEM_ADDR_W;
  localparam CW = `COUNT_W;
  localparam [CW-1:0] CNT_ONE  = {{(CW-1){1'b0}}, 1'b1};
  localparam [AW-1:0] ADDR_ONE = {{(AW-1){1'b0}}, 1'b1};

  // one-hot comparison states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SRC  = 4'b0010;
  localparam [3:0] ST_DST  = 4'b0100;
  localparam [3:0] ST_CMP  = 4'b1000;

  reg  [3:0]     state_reg;
  reg  [3:0]     state_next;
  reg  [AW-1:0]  srcBase_reg;
  reg  [AW-1:0]  srcBase_next;
  reg  [AW-1:0]  dstBase_reg;
  reg  [AW-1:0]  dstBase_next;
  reg  [CW-1:0]  count_reg;
  reg  [CW-1:0]  count_next;
  reg  [CW-1:0]  idx_reg;
  reg  [CW-1:0]  idx_next;
  reg  [7:0]     srcByte_reg;
  reg  [7:0]     srcByte_next;
  reg  [AW-1:0]  memAddr_next;
  reg            memRd_next;
  reg            equal_next;
  reg            busy_next;
  reg            doneEvt;
  reg            mismatchEvt;
  reg  [7:0]     ctrl_reg;
  reg  [`EVT_W-1:0] mask_reg;
  reg            anyErr_reg;
  reg  [7:0]     rdData_next;

  wire           chkOverrun;
  wire           chkOverlap;
  wire           chkBounds;
  wire           anyErrNow;
  wire           errEvt;
  wire           honorEnable;
  wire           active;
  wire           lastByte;
  wire [AW-1:0]  srcAddr;
  wire [AW-1:0]  dstAddr;
  wire [`EVT_W-1:0] statusBits;
  wire [`EVT_W-1:0] eventVec;
  wire           statusClear;
  wire           ctrlSel;
  wire           statusSel;
  wire           maskSel;

  range_limit_check #(
    .OFFSET_W  (OFFSET_W),
    .MEM_BYTES (MEM_BYTES),
    .MAX_COUNT (MAX_COUNT)
  ) uCheck (
    .srcOffset   (sourceStartOffset),
    .dstOffset   (destStartOffset),
    .count       (byteCount),
    .overrun     (chkOverrun),
    .overlap     (chkOverlap),
    .outOfBounds (chkBounds)
  );

  assign anyErrNow   = chkOverrun | chkOverlap | chkBounds;
  // the error event marks the start of an error episode, not every cycle of it
  assign errEvt      = anyErrNow & ~anyErr_reg;
  assign honorEnable = ctrl_reg[`CTRL_HONOR_EN];

  assign active = ~honorEnable | enableIn;

  // upper region bytewise
  // sums stay inside memory: a start is refused while a range check fails
  assign srcAddr  = srcBase_reg + {{(AW-CW){1'b0}}, idx_reg};
  assign dstAddr  = dstBase_reg + {{(AW-CW){1'b0}}, idx_reg};
  // count is at least one once running, so count minus one cannot wrap
  assign lastByte = (idx_reg == count_reg - CNT_ONE);

  // checks every cycle
  // flags follow the live inputs, so a bad setup shows before any start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countOverrunError <= 1'b0;
      rangeOverlapError <= 1'b0;
      outOfBoundsError  <= 1'b0;
      anyErr_reg        <= 1'b0;
    end else if (ce) begin
      countOverrunError <= chkOverrun;
      rangeOverlapError <= chkOverlap;
      outOfBoundsError  <= chkBounds;
      anyErr_reg        <= anyErrNow;
    end
  end

  // comparison sequencer: three cycles per byte pair
  always @* begin
    state_next   = state_reg;
    srcBase_next = srcBase_reg;
    dstBase_next = dstBase_reg;
    count_next   = count_reg;
    idx_next     = idx_reg;
    srcByte_next = srcByte_reg;
    memAddr_next = memAddr;
    memRd_next   = 1'b0;
    equal_next   = rangesEqualFlag;
    busy_next    = busy;
    doneEvt      = 1'b0;
    mismatchEvt  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (evalStart) begin
          if (!active || anyErrNow) begin
            equal_next = 1'b0;
            // a disabled unit stays silent; an error still ends the cycle
            doneEvt    = active;
          end else begin
            srcBase_next = sourceStartOffset[AW-1:0];
            dstBase_next = destStartOffset[AW-1:0];
            count_next   = byteCount[CW-1:0];
            idx_next     = {CW{1'b0}};
            // first fetch leaves with the start to save a cycle
            memAddr_next = sourceStartOffset[AW-1:0];
            memRd_next   = 1'b1;
            busy_next    = 1'b1;
            state_next   = ST_SRC;
          end
        end
      end
      ST_SRC: begin
        // source byte in flight; request the destination byte
        memAddr_next = dstAddr;
        memRd_next   = 1'b1;
        state_next   = ST_DST;
      end
      ST_DST: begin
        // source byte arrives; destination byte follows next cycle
        srcByte_next = memRdData;
        state_next   = ST_CMP;
      end
      ST_CMP: begin
        if (memRdData != srcByte_reg) begin
          equal_next  = 1'b0;
          mismatchEvt = 1'b1;
          doneEvt     = 1'b1;
          busy_next   = 1'b0;
          state_next  = ST_IDLE;
        end else if (lastByte) begin
          equal_next = 1'b1;
          doneEvt    = 1'b1;
          busy_next  = 1'b0;
          state_next = ST_IDLE;
        end else begin
          idx_next     = idx_reg + CNT_ONE;
          memAddr_next = srcAddr + ADDR_ONE;
          memRd_next   = 1'b1;
          state_next   = ST_SRC;
        end
      end
      default: begin
        busy_next  = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
    if (!active && state_reg != ST_IDLE) begin
      // abandon the run; a partial match must not read as equal
      memRd_next  = 1'b0;
      equal_next  = 1'b0;
      doneEvt     = 1'b0;
      mismatchEvt = 1'b0;
      busy_next   = 1'b0;
      state_next  = ST_IDLE;
    end
    if (anyErrNow) begin
      equal_next = 1'b0;
    end
  end

  // all state from reset
  // ce low freezes the sequencer and its memory strobe together
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_IDLE;
      srcBase_reg     <= {AW{1'b0}};
      dstBase_reg     <= {AW{1'b0}};
      count_reg       <= {CW{1'b0}};
      idx_reg         <= {CW{1'b0}};
      srcByte_reg     <= 8'h00;
      memAddr         <= {AW{1'b0}};
      memRd           <= 1'b0;
      rangesEqualFlag <= 1'b0;
      busy            <= 1'b0;
    end else if (ce) begin
      state_reg       <= state_next;
      srcBase_reg     <= srcBase_next;
      dstBase_reg     <= dstBase_next;
      count_reg       <= count_next;
      idx_reg         <= idx_next;
      srcByte_reg     <= srcByte_next;
      memAddr         <= memAddr_next;
      memRd           <= memRd_next;
      rangesEqualFlag <= equal_next;
      busy            <= busy_next;
    end
  end

  // event capture and interrupt
  // done marks every evaluation that ended, matched or not, except a start refused or a run abandoned while enable is honoured and low
  assign eventVec[`EVT_DONE]     = doneEvt;
  assign eventVec[`EVT_MISMATCH] = mismatchEvt;
  assign eventVec[`EVT_ERROR]    = errEvt;
  // this index decode serves the write path; the read path decodes regAddr in its own case
  assign ctrlSel     = (regAddr == `REG_CTRL);
  assign statusSel   = (regAddr == `REG_STATUS);
  assign maskSel     = (regAddr == `REG_MASK);

  assign statusClear = regWr && statusSel;

  event_status #(
    .W (`EVT_W)
  ) uStatus (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .setEvents  (eventVec),
    .clearWrite (statusClear),
    .clearBits  (regWrData[`EVT_W-1:0]),
    .statusBits (statusBits)
  );

  // register writes
  // result is read-only; writes to it or to unmapped indices are dropped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= `MASK_RESET;
      irq      <= 1'b0;
    end else if (ce) begin
      if (regWr && ctrlSel) begin
        ctrl_reg <= {7'h00, regWrData[`CTRL_HONOR_EN]};
      end
      if (regWr && maskSel) begin
        mask_reg <= regWrData[`EVT_W-1:0];
      end
      irq <= |(statusBits & mask_reg);
    end
  end

  // register reads, data in the following cycle
  // an idle port returns zero so stale data never reads as fresh
  always @* begin
    rdData_next = 8'h00;
    case (regAddr)
      `REG_CTRL: begin
        rdData_next = ctrl_reg;
      end
      `REG_STATUS: begin
        rdData_next = {{(8-`EVT_W){1'b0}}, statusBits};
      end
      `REG_MASK: begin
        rdData_next = {{(8-`EVT_W){1'b0}}, mask_reg};
      end
      `REG_RESULT: begin
        rdData_next[`RES_EQUAL]   = rangesEqualFlag;
        rdData_next[`RES_OVERRUN] = countOverrunError;
        rdData_next[`RES_OVERLAP] = rangeOverlapError;
        rdData_next[`RES_BOUNDS]  = outOfBoundsError;
        rdData_next[`RES_BUSY]    = busy;
      end
      default: begin
        rdData_next = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (ce) begin
      regRdData <= regRd ? rdData_next : 8'h00;
    end
  end
endmodule // marker_block_compare

// ===== tb/marker_memory_model.sv
`timescale 1ns/1ps
module marker_memory_model (
  input  logic       clk,
  input  logic [9:0] memAddr,
  input  logic       memRd,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:1023];
  initial memRdData = 8'h00;
  // stale data is inverted so a late sample never matches by chance
  always @(posedge clk) begin
    if (memRd) memRdData <= mem[memAddr];
    else memRdData <= ~memRdData;
  end
endmodule // marker_memory_model

// ===== tb/marker_block_compare_chk.sv
`timescale 1ns/1ps
module marker_block_compare_chk #(
  parameter OFFSET_W = 32
) (
  input logic                clk,
  input logic                rst_n,
  input logic                ce,
  input logic                evalStart,
  input logic                enableIn,
  input logic [OFFSET_W-1:0] sourceStartOffset,
  input logic [OFFSET_W-1:0] destStartOffset,
  input logic [OFFSET_W-1:0] byteCount,
  input logic [3:0]          regAddr,
  input logic [7:0]          regWrData,
  input logic                regWr,
  input logic [9:0]          memAddr,
  input logic                memRd,
  input logic                rangesEqualFlag,
  input logic                countOverrunError,
  input logic                rangeOverlapError,
  input logic                outOfBoundsError,
  input logic                busy
);
  logic hon;
  wire [OFFSET_W-1:0] s = sourceStartOffset;
  wire [OFFSET_W-1:0] d = destStartOffset;
  wire [OFFSET_W-1:0] n = byteCount;
  wire bnd = n == 0 || s >= 1024 || d >= 1024;
  wire ovr = !bnd && (n > 192 || s + n > 1024 || d + n > 1024);
  wire ovl = n != 0 && s < d + n && d < s + n;
  wire go = ce && evalStart && !busy;
  wire anyErr = countOverrunError || rangeOverlapError || outOfBoundsError;
  // mirror of the enable-honour control bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) hon <= 1'b1;
    else if (ce && regWr && regAddr == 4'h0) hon <= regWrData[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  bounds_flag_a: assert property (ce |=> outOfBoundsError == $past(bnd))
    else $error("bounds flag wrong");
  overrun_flag_a: assert property (ce |=> countOverrunError == $past(ovr))
    else $error("overrun flag wrong");
  overlap_flag_a: assert property (ce |=> rangeOverlapError == $past(ovl))
    else $error("overlap flag wrong");
  error_unequal_a: assert property (anyErr |-> !rangesEqualFlag)
    else $error("equal flag high beside an error");
  disabled_eval_a: assert property (go && hon && !enableIn |=> !busy && !rangesEqualFlag)
    else $error("evaluation ran while disabled");
  start_fetch_a: assert property (go && (!hon || enableIn) && !(bnd || ovr || ovl) |=>
    busy && memRd && memAddr == $past(s[9:0]) ##1 memRd && memAddr == $past(d[9:0], 2))
    else $error("first fetch addresses wrong");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:600] !busy)
    else $error("comparison too long");
  idle_memory_a: assert property (!busy |-> !memRd)
    else $error("memory read while idle");
  enable_drop_a: assert property (ce && busy && hon && !enableIn |=> !busy)
    else $error("comparison kept running while disabled");
  cover property (go && !(bnd || ovr || ovl));
  cover property (ovl && bnd == 1'b0);
  cover property ($fell(busy) && rangesEqualFlag);
endmodule // marker_block_compare_chk

bind marker_block_compare marker_block_compare_chk #(.OFFSET_W(OFFSET_W)) chk_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce), .evalStart(evalStart), .enableIn(enableIn),
  .sourceStartOffset(sourceStartOffset), .destStartOffset(destStartOffset),
  .byteCount(byteCount), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .memAddr(memAddr), .memRd(memRd), .rangesEqualFlag(rangesEqualFlag),
  .countOverrunError(countOverrunError), .rangeOverlapError(rangeOverlapError),
  .outOfBoundsError(outOfBoundsError), .busy(busy));

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_n, ce, evalStart, enableIn, regWr, regRd;
  logic        memRd, eqF, ovrE, ovlE, bndE, busy, irq;
  logic [31:0] src, dst, cnt;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData, regRdData, memRdData;
  logic [9:0]  memAddr;
  int          fail_count, checks, i;

  marker_block_compare marker_block_compare_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .evalStart(evalStart), .enableIn(enableIn), .sourceStartOffset(src),
    .destStartOffset(dst), .byteCount(cnt), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memAddr(memAddr),
    .memRd(memRd), .memRdData(memRdData), .rangesEqualFlag(eqF),
    .countOverrunError(ovrE), .rangeOverlapError(ovlE), .outOfBoundsError(bndE),
    .busy(busy), .irq(irq));
  marker_memory_model marker_memory_model_inst (.clk(clk), .memAddr(memAddr),
    .memRd(memRd), .memRdData(memRdData));

  task summarize;
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  task run(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n);
    @(posedge clk);
    src <= s;
    dst <= d;
    cnt <= n;
    evalStart <= 1'b1;
    @(posedge clk);
    evalStart <= 1'b0;
    #1;
    for (i = 0; busy !== 1'b0; i++) begin
      if (i == 1000) begin
        fail_count++;
        summarize();
      end
      @(posedge clk);
      #1;
    end
  endtask
  task errc(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n,
            input logic [2:0] e);
    @(posedge clk);
    src <= s;
    dst <= d;
    cnt <= n;
    @(posedge clk);
    #1;
    chk({5'h00, ovrE, ovlE, bndE}, {5'h00, e});
    if (e != 3'h0) chk(eqF, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_n, evalStart, regWr, regRd, regAddr, regWrData} = '0;
    {ce, enableIn} = 2'b11;
    src = 10;
    dst = 380;
    cnt = 4;
    fail_count = 0;
    checks = 0;
    for (i = 0; i < 1024; i++) marker_memory_model_inst.mem[i] = 8'h5a;
    marker_memory_model_inst.mem[13] = 8'h33;
    marker_memory_model_inst.mem[383] = 8'h33;
    marker_memory_model_inst.mem[987] = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(0, 8'h01);
    rd(2, 8'h00);
    rd(9, 8'h00);
    wr(2, 8'h07);
    wr(1, 8'h07);
    run(10, 380, 4);
    chk(eqF, 1'b1);
    rd(3, 8'h01);
    rd(1, 8'h01);
    chk(irq, 1'b1);
    wr(1, 8'h01);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wr(2, 8'h00);
    run(10, 381, 4);
    chk(eqF, 1'b0);
    chk(irq, 1'b0);
    rd(1, 8'h03);
    run(1023, 0, 1);
    chk(eqF, 1'b1);
    run((300 - 1) * 2, (200 - 1) * 4, 191);
    chk(eqF, 1'b1);
    run(598, 796, 192);
    chk(eqF, 1'b0);
    @(posedge clk) evalStart <= 1'b1;
    @(posedge clk) evalStart <= 1'b0;
    @(posedge clk) enableIn <= 1'b0;
    @(posedge clk);
    #1;
    chk(busy, 1'b0);
    run(10, 380, 4);
    chk(eqF, 1'b0);
    wr(0, 8'h00);
    run(10, 380, 4);
    chk(eqF, 1'b1);
    @(posedge clk) evalStart <= 1'b1;
    @(posedge clk) evalStart <= 1'b0;
    @(posedge clk) rst_n <= 1'b0;
    #1;
    chk(busy, 1'b0);
    chk(eqF, 1'b0);
    @(posedge clk) rst_n <= 1'b1;
    rd(0, 8'h01);
    errc(23, 30, 4, 3'h0);
    errc(0, 100, 0, 3'h1);
    errc(1024, 0, 4, 3'h1);
    errc(0, 1024, 4, 3'h1);
    errc(1000, 0, 30, 3'h4);
    errc(0, 100, 193, 3'h6);
    errc(23, 30, 8, 3'h2);
    @(posedge clk) ce <= 1'b0;
    wr(2, 8'h05);
    errc(1024, 1024, 0, 3'h2);
    @(posedge clk) ce <= 1'b1;
    errc(1024, 1024, 0, 3'h1);
    rd(2, 8'h00);
    summarize();
  end
endmodule // testbench
